// file: logic/dis_top.sv
// door interlock sequencer: door-open stop sequence, door flag, speed clamp
//
// Function
// - door request rise: decelerate and interlock all axes
// - all stopped: cut contactors, keep servo ready complete
// - after cut: assert door open enable
// - request fall: ready and servo on again
// - request fall: drop door open enable
// - moving sequence axis: dynamic brake, keep remaining distance
// - door flag reads one while door open
// - mismatch with amp door close 3 s: alarm
// - clamp input limits spindle to alternate clamp
// - per operation normal or door clamp parameter
// - clamp input ignored unless setting bit 5
// - door clamp taken without magnitude compare
// - orient, tap, c-axis return latch clamp at start
// - routing 0 or one system: first input governs
// - door open enable reports door may open
`timescale 1ns/10ps
`default_nettype none
module dis_top import dis_pkg::*; #(
  parameter int unsigned ALARM_CYC = ALARM_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              door_open_req,
  input  wire logic [1:0]        clamp_req,
  input  wire logic              all_axes_stopped,
  input  wire logic              plc_axis_moving,
  input  wire logic              amp_door_close,
  input  wire logic              op_active,
  input  wire logic [1:0]        op_kind,
  input  wire logic [15:0]       plc_axis_remain,
  output dis_amp_s               amp_q,
  output logic                   door_open_enable_q,
  output logic                   door_state_flag_q,
  output logic                   alarm_5d_q,
  output logic [15:0]            clamp_ch1_q,
  output logic [15:0]            clamp_ch2_q
);
  if (ALARM_CYC < 1) begin : g_chk
    $error("ALARM_CYC must be at least one");
  end

  // ------------------------------------------------------------------
  // input sampling
  // ------------------------------------------------------------------
  logic [5:0]  raw;
  logic [5:0]  sync1_q;
  logic [5:0]  sync2_q;
  logic [5:0]  prev_q;
  logic        door_s, door_p, stop_s, moving_s, close_s;
  logic [1:0]  clamp_s;
  assign raw = {amp_door_close, plc_axis_moving, all_axes_stopped, clamp_req, door_open_req};
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      prev_q  <= 6'h00;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  assign door_s   = sync2_q[0];
  assign door_p   = prev_q[0];
  assign clamp_s  = sync2_q[2:1];
  assign stop_s   = sync2_q[3];
  assign moving_s = sync2_q[4];
  assign close_s  = sync2_q[5];

  // ------------------------------------------------------------------
  // door open sequence
  // ------------------------------------------------------------------
  dis_state_e state_q, state_d;
  logic       door_rise;
  assign door_rise = door_s && !door_p;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (door_rise) state_d = ST_DECEL;
      ST_DECEL: if (stop_s) state_d = ST_CUT;
      ST_CUT:   state_d = ST_OPEN;
      ST_OPEN:  state_d = ST_OPEN;
    endcase
    if (!door_s) state_d = ST_IDLE;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q            <= ST_IDLE;
      amp_q              <= '0;
      door_open_enable_q <= 1'b0;
      door_state_flag_q  <= 1'b0;
    end else begin
      state_q                   <= state_d;
      amp_q.axis_interlock      <= state_d != ST_IDLE;
      amp_q.decel_stop          <= state_d != ST_IDLE;
      amp_q.contactor_on        <= state_d inside {ST_IDLE, ST_DECEL};
      amp_q.ready_on            <= state_d inside {ST_IDLE, ST_DECEL};
      amp_q.servo_on            <= state_d inside {ST_IDLE, ST_DECEL};
      amp_q.servo_ready_complete <= 1'b1;
      // a sequence axis moving at the request rise brakes at once, before the cut, until the request falls
      amp_q.dyn_brake           <= door_s && (amp_q.dyn_brake || (door_rise && moving_s));
      door_open_enable_q        <= state_d == ST_OPEN;
      door_state_flag_q         <= state_d == ST_OPEN;
    end
  end

  // ------------------------------------------------------------------
  // remaining distance and door mismatch alarm
  // ------------------------------------------------------------------
  logic [15:0] remain_q;
  logic [31:0] mis_cnt_q;
  logic        mis_full;
  logic        alarm_clr;
  assign mis_full = mis_cnt_q >= ALARM_CYC - 1;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) remain_q <= 16'h0000;
    else if (door_rise && moving_s) remain_q <= plc_axis_remain;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mis_cnt_q  <= 32'h0000_0000;
      alarm_5d_q <= 1'b0;
    end else begin
      // compatible when flag (open) and close input differ
      if (door_state_flag_q != close_s) mis_cnt_q <= 32'h0000_0000;
      else if (!mis_full) mis_cnt_q <= mis_cnt_q + 32'h0000_0001;
      if (door_state_flag_q == close_s && mis_full) alarm_5d_q <= 1'b1;
      else if (alarm_clr) alarm_5d_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // register file over AXI4-Lite
  // ------------------------------------------------------------------
  logic [31:0]       cfg_q;
  logic [15:0]       param_q [NUM_PARAM];
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_full_q, w_full_q, do_wr;
  logic [31:0]       rd_d;
  logic              rd_ok;
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i +: 8] = d[8*i +: 8];
    end
    return o;
  endfunction
  function automatic logic addr_ok(input logic [AXI_AW-1:0] a);
    return a[1:0] == 2'b00 && a <= OFS_REMAIN;
  endfunction
  assign do_wr         = aw_full_q && w_full_q && !s_axi_bvalid;
  assign alarm_clr     = do_wr && awaddr_q == OFS_STATUS && wstrb_q[0] && wdata_q[STS_ALARM_BIT];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      // ready kept in a flop, always the inverse of the holding flag
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RST;
      for (int i = 0; i < NUM_PARAM; i++) param_q[i] <= CLAMP_RST;
    end else if (do_wr) begin
      if (awaddr_q == OFS_CFG) cfg_q <= merge(cfg_q, wdata_q, wstrb_q);
      for (int i = 0; i < NUM_PARAM; i++) begin
        if (awaddr_q == OFS_PARAM0 + 6'(4 * i))
          param_q[i] <= 16'(merge({16'h0000, param_q[i]}, wdata_q, wstrb_q));
      end
    end
  end
  always_comb begin
    rd_d  = 32'h0000_0000;
    rd_ok = addr_ok(s_axi_araddr);
    if (s_axi_araddr == OFS_CFG) rd_d = cfg_q;
    else if (s_axi_araddr == OFS_STATUS)
      rd_d = {22'h000000, state_q, door_open_enable_q, door_state_flag_q, close_s, stop_s,
              clamp_s, door_s, alarm_5d_q};
    else if (s_axi_araddr == OFS_REMAIN) rd_d = {16'h0000, remain_q};
    else if (s_axi_araddr >= OFS_PARAM0 && s_axi_araddr <= OFS_PARAM5)
      rd_d = {16'h0000, param_q[3'(6'(s_axi_araddr - OFS_PARAM0) >> 2)]};
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_ok ? rd_d : 32'h0000_0000;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      s_axi_arready <= 1'b0;
    end else if (s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // door interlock speed clamp
  // ------------------------------------------------------------------
  logic [1:0] eff;
  logic [1:0] lat_q;
  logic [1:0] use_door;
  logic       op_p_q, en, split;
  assign en    = cfg_q[CFG_CLAMP_EN_BIT];
  assign split = cfg_q[CFG_ROUTE_BIT] && cfg_q[CFG_TWO_SYS_BIT];
  assign eff[0] = en && clamp_s[0];
  assign eff[1] = en && (split ? clamp_s[1] : clamp_s[0]);
  // indexing follows the live input; others hold the value at start
  assign use_door = (dis_op_e'(op_kind) == OP_INDEX) ? eff : lat_q;
  function automatic logic [15:0] pick(input logic [1:0] k, input logic d,
                                       input logic [15:0] p [NUM_PARAM]);
    // no magnitude compare: the door value wins while selected
    unique case (dis_op_e'(k))
      OP_ORIENT: return d ? p[PI_DOOR_SH] : p[PI_ORIENT_N];
      OP_INDEX:  return d ? p[PI_INDEX_D] : p[PI_INDEX_N];
      OP_TAP:    return d ? p[PI_DOOR_SH] : p[PI_TAP_N];
      OP_CAXIS:  return d ? p[PI_DOOR_SH] : p[PI_CAXIS_N];
    endcase
  endfunction
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      op_p_q      <= 1'b0;
      lat_q       <= 2'b00;
      clamp_ch1_q <= CLAMP_RST;
      clamp_ch2_q <= CLAMP_RST;
    end else begin
      op_p_q <= op_active;
      if (op_active && !op_p_q) lat_q <= eff;
      if (op_active && !op_p_q) begin
        clamp_ch1_q <= pick(op_kind, eff[0], param_q);
        clamp_ch2_q <= pick(op_kind, eff[1], param_q);
      end else begin
        clamp_ch1_q <= pick(op_kind, use_door[0], param_q);
        clamp_ch2_q <= pick(op_kind, use_door[1], param_q);
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_rise_decel: assert property (door_rise && state_q == ST_IDLE |=> amp_q.decel_stop && amp_q.axis_interlock)
    else $error("no stop after door request");
  chk_cut_keep_ready: assert property (state_q == ST_DECEL && stop_s && door_s |=> !amp_q.contactor_on && amp_q.servo_ready_complete ##1 door_open_enable_q || !door_s)
    else $error("cut sequence wrong");
  chk_enable_after_cut: assert property ($rose(door_open_enable_q) |-> $past(state_q) == ST_CUT && !amp_q.contactor_on)
    else $error("enable before cut");
  chk_fall_restore: assert property (door_p && !door_s |=> amp_q.ready_on && amp_q.servo_on && !door_open_enable_q)
    else $error("no restore on fall");
  chk_brake_capture: assert property (door_rise && moving_s |=> amp_q.dyn_brake && remain_q == $past(plc_axis_remain))
    else $error("brake or remain missing");
  chk_door_flag: assert property (door_state_flag_q |-> $past(door_s) && !amp_q.contactor_on)
    else $error("door flag wrong");
  chk_alarm_time: assert property ($rose(alarm_5d_q) |-> $past(mis_full) && $past(door_state_flag_q == close_s))
    else $error("alarm too early");
  chk_clamp_gate: assert property (!en && !op_p_q && op_active && dis_op_e'(op_kind) == OP_ORIENT |=> clamp_ch1_q == param_q[PI_ORIENT_N])
    else $error("clamp used while disabled");
  chk_latch_hold: assert property (op_active && op_p_q |=> $stable(lat_q))
    else $error("latched clamp changed");
  chk_route_single: assert property (op_active && !op_p_q && !split |=> clamp_ch1_q == clamp_ch2_q)
    else $error("routing wrong");
  cov_open: cover property (door_rise ##[1:20] door_open_enable_q);
  cov_brake: cover property (door_rise && moving_s);
  cov_door_clamp: cover property (op_active && use_door[0]);
  cov_alarm: cover property ($rose(alarm_5d_q));
endmodule // dis_top
`default_nettype wire

// file: logic/dis_pkg.sv
// package: constants, types and carriers of the door interlock sequencer
`default_nettype none
package dis_pkg;
  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int          AXI_AW     = 6;
  localparam logic [5:0]  OFS_CFG    = 6'h00;
  localparam logic [5:0]  OFS_PARAM0 = 6'h04;
  localparam logic [5:0]  OFS_PARAM5 = 6'h18;
  localparam logic [5:0]  OFS_STATUS = 6'h1C;
  localparam logic [5:0]  OFS_REMAIN = 6'h20;
  localparam int          NUM_PARAM  = 6;
  localparam int          PI_ORIENT_N = 0;
  localparam int          PI_DOOR_SH  = 1;
  localparam int          PI_INDEX_N  = 2;
  localparam int          PI_INDEX_D  = 3;
  localparam int          PI_TAP_N    = 4;
  localparam int          PI_CAXIS_N  = 5;
  localparam int          CFG_CLAMP_EN_BIT = 5;
  localparam int          CFG_ROUTE_BIT    = 8;
  localparam int          CFG_TWO_SYS_BIT  = 9;
  localparam int          STS_ALARM_BIT    = 0;
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  localparam logic [15:0] CLAMP_RST  = 16'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned ALARM_TIME_MS = 3000;
  localparam int unsigned ALARM_CYCLES  = ALARM_TIME_MS * (CLK_HZ / 1000);
  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DECEL = 2'b01,
    ST_CUT   = 2'b10,
    ST_OPEN  = 2'b11
  } dis_state_e;
  typedef enum logic [1:0] {
    OP_ORIENT = 2'b00,
    OP_INDEX  = 2'b01,
    OP_TAP    = 2'b10,
    OP_CAXIS  = 2'b11
  } dis_op_e;
  typedef struct packed {
    logic axis_interlock;
    logic decel_stop;
    logic contactor_on;
    logic ready_on;
    logic servo_on;
    logic servo_ready_complete;
    logic dyn_brake;
  } dis_amp_s;
endpackage
`default_nettype wire

// file: dv/dis_partner.sv
// partner model: sequence program and amplifiers around the door sequencer
`timescale 1ns/10ps
`default_nettype none
module dis_partner import dis_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire dis_amp_s   amp,
  input  wire logic       door_flag,
  input  wire logic [7:0] stop_dly,
  input  wire logic       disagree,
  output logic            all_axes_stopped,
  output logic            amp_door_close
);
  // ------------------------------------------------------------------
  // axes coast down for stop_dly + 1 scans, then report stopped
  // ------------------------------------------------------------------
  logic [7:0] cnt_q;
  // program confirms spindle stop itself and keeps run commands off
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q            <= 8'h00;
      all_axes_stopped <= 1'b0;
    end else if (amp.ready_on && !amp.decel_stop) begin
      cnt_q            <= 8'h00;
      all_axes_stopped <= 1'b0;
    end else if (amp.decel_stop && !all_axes_stopped) begin
      cnt_q            <= cnt_q + 8'h01;
      all_axes_stopped <= (cnt_q >= stop_dly);
    end
  end
  // amp door switch: 1 while closed; disagree only when the bench asks
  assign amp_door_close = ~door_flag ^ disagree;
endmodule // dis_partner
`default_nettype wire

// file: dv/tb_top.sv
// testbench: door stop sequence, clamp routing, door alarm and register access
`timescale 1ns/10ps
`default_nettype none
module tb_top import dis_pkg::*; ;
  // ------------------------------------------------------------------
  // signals and clamp table
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cfg;
    logic [1:0]  clamp;
    logic [1:0]  op;
    logic [15:0] e1;
    logic [15:0] e2;
  } dis_row_s;
  localparam logic [15:0] PV [NUM_PARAM] = '{16'h1000, 16'h0100, 16'h2000, 16'h0200, 16'h3000, 16'h4000};
  localparam dis_row_s ROWS [13] = '{
    '{32'h000, 2'h3, 2'h0, 16'h1000, 16'h1000}, '{32'h020, 2'h0, 2'h0, 16'h1000, 16'h1000},
    '{32'h020, 2'h1, 2'h0, 16'h0100, 16'h0100}, '{32'h020, 2'h1, 2'h1, 16'h0200, 16'h0200},
    '{32'h020, 2'h0, 2'h1, 16'h2000, 16'h2000}, '{32'h020, 2'h1, 2'h2, 16'h0100, 16'h0100},
    '{32'h020, 2'h0, 2'h2, 16'h3000, 16'h3000}, '{32'h020, 2'h1, 2'h3, 16'h0100, 16'h0100},
    '{32'h020, 2'h0, 2'h3, 16'h4000, 16'h4000}, '{32'h320, 2'h2, 2'h0, 16'h1000, 16'h0100},
    '{32'h320, 2'h1, 2'h0, 16'h0100, 16'h1000}, '{32'h120, 2'h2, 2'h0, 16'h1000, 16'h1000},
    '{32'h220, 2'h2, 2'h0, 16'h1000, 16'h1000}};
  logic        mclk, rstn, door_open_req, all_axes_stopped, plc_axis_moving, amp_door_close, op_active, disagree;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, clamp_req, op_kind;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        door_open_enable_q, door_state_flag_q, alarm_5d_q;
  logic [15:0] plc_axis_remain, clamp_ch1_q, clamp_ch2_q;
  logic [7:0]  stop_dly;
  dis_amp_s    amp_q;
  int          fail_count, compares, cyc;
  // short alarm count keeps the run brief
  dis_top #(.ALARM_CYC(20)) dis_top_inst (.mclk(mclk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .door_open_req(door_open_req), .clamp_req(clamp_req), .all_axes_stopped(all_axes_stopped),
    .plc_axis_moving(plc_axis_moving), .amp_door_close(amp_door_close), .op_active(op_active),
    .op_kind(op_kind), .plc_axis_remain(plc_axis_remain), .amp_q(amp_q), .door_open_enable_q(door_open_enable_q),
    .door_state_flag_q(door_state_flag_q), .alarm_5d_q(alarm_5d_q), .clamp_ch1_q(clamp_ch1_q),
    .clamp_ch2_q(clamp_ch2_q));
  dis_partner dis_partner_inst (.mclk(mclk), .rstn(rstn), .amp(amp_q), .door_flag(door_state_flag_q),
    .stop_dly(stop_dly), .disagree(disagree), .all_axes_stopped(all_axes_stopped), .amp_door_close(amp_door_close));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bus tasks hold each channel until its own handshake edge
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1;
      end
    end
    @(posedge mclk);
  endtask
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1;
      end
    end
    @(posedge mclk);
  endtask
  task automatic wait_open();
    int n;
    n = 0;
    while (door_open_enable_q !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic door_cycle(input logic [7:0] dly);
    stop_dly <= dly;
    door_open_req <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(amp_q, 7'h7E);
    chk(door_open_enable_q, 1'b0);
    wait_open();
    chk(all_axes_stopped, 1'b1);
    chk({amp_q.contactor_on, amp_q.ready_on, amp_q.servo_on, amp_q.servo_ready_complete}, 4'h1);
    chk({door_open_enable_q, door_state_flag_q}, 2'h3);
    door_open_req <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(amp_q, 7'h1E);
    chk({door_open_enable_q, door_state_flag_q}, 2'h0);
    endt("door cycle");
  endtask
  task automatic latch_case(input logic [1:0] op, input logic [15:0] exp);
    clamp_req <= 2'h0;
    op_kind <= op;
    repeat (4) @(posedge mclk);
    op_active <= 1'b1;
    repeat (2) @(posedge mclk);
    clamp_req <= 2'h1;
    repeat (6) @(posedge mclk);
    chk(clamp_ch1_q, exp);
    op_active <= 1'b0;
    @(posedge mclk);
  endtask
  // ------------------------------------------------------------------
  // clock, timeout and sequence
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    {rstn, door_open_req, plc_axis_moving, op_active, disagree, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, clamp_req, op_kind} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, plc_axis_remain} = '0;
    stop_dly = 8'h01;
    repeat (2) @(posedge mclk);
    chk(amp_q, 7'h00);
    @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(amp_q, 7'h1E);
    axi_rd(OFS_CFG, rd, rsp);
    chk(rd, CFG_RST);
    axi_rd(6'h24, rd, rsp);
    chk(rd, 32'h0);
    chk(rsp, RESP_SLVERR);
    axi_wr(6'h02, 32'h1, rsp);
    chk(rsp, RESP_SLVERR);
    for (int i = 0; i < NUM_PARAM; i++) axi_wr(OFS_PARAM0 + 6'(4 * i), {16'hFFFF, PV[i]}, rsp);
    axi_rd(OFS_PARAM0, rd, rsp);
    chk(rd, {16'h0, PV[0]});
    endt("registers");
    foreach (ROWS[i]) begin
      axi_wr(OFS_CFG, ROWS[i].cfg, rsp);
      clamp_req <= ROWS[i].clamp;
      op_kind <= ROWS[i].op;
      repeat (4) @(posedge mclk);
      op_active <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({clamp_ch1_q, clamp_ch2_q}, {ROWS[i].e1, ROWS[i].e2});
      op_active <= 1'b0;
      @(posedge mclk);
    end
    endt("clamp table");
    latch_case(OP_TAP, PV[PI_TAP_N]);
    latch_case(OP_CAXIS, PV[PI_CAXIS_N]);
    latch_case(OP_INDEX, PV[PI_INDEX_D]); // index follows the live input
    endt("clamp latch");
    door_cycle(8'h01); // sequence axis held still first
    door_cycle(8'h0C);
    plc_axis_moving <= 1'b1;
    plc_axis_remain <= 16'h1234;
    door_open_req <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(amp_q, 7'h7F);
    plc_axis_moving <= 1'b0;
    wait_open();
    axi_rd(OFS_REMAIN, rd, rsp);
    chk(rd, 32'h1234);
    rstn <= 1'b0;
    door_open_req <= 1'b0;
    @(posedge mclk);
    chk({amp_q, door_open_enable_q}, 8'h00);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(amp_q, 7'h1E);
    endt("brake and reset");
    // two sync stages, then twenty mismatch scans before the alarm
    disagree <= 1'b1;
    repeat (21) @(posedge mclk);
    chk(alarm_5d_q, 1'b0);
    repeat (2) @(posedge mclk);
    disagree <= 1'b0;
    chk(alarm_5d_q, 1'b1);
    repeat (4) @(posedge mclk);
    axi_wr(OFS_STATUS, 32'h1, rsp);
    axi_rd(OFS_STATUS, rd, rsp);
    chk(rd[STS_ALARM_BIT], 1'b0);
    endt("alarm");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
